// File: rtl/bcdf_top.sv
// Balancing current diagnosis flags: per-cell overcurrent and
// undercurrent flags, balancing gate, general diagnosis clear,
// interrupt. Assumes APB master and detectors on clk_i (10 MHz).
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
module bcdf_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [bcdf_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [bcdf_pkg::DATA_W-1:0] pwdata_i,
	output logic pready_o,
	output logic [bcdf_pkg::DATA_W-1:0] prdata_o,
	output logic pslverr_o,
	// Fault detectors, one bit per cell
	input wire logic [bcdf_pkg::CELLS-1:0] oc_detect_i,
	input wire logic [bcdf_pkg::CELLS-1:0] uc_detect_i,
	// Balancing switch enables and interrupt
	output logic [bcdf_pkg::CELLS-1:0] bal_en_o,
	output logic irq_o
);
	import bcdf_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	bcdf_reg_if rf ();

	logic [CELLS-1:0] oc_flags;
	logic [CELLS-1:0] uc_flags;
	logic [CELLS-1:0] oc_clr;
	logic [CELLS-1:0] uc_clr;
	logic oc_rise;
	logic uc_rise;
	logic wr_oc, wr_uc, wr_gen, wr_bal, wr_sts, wr_msk;

	logic [CELLS-1:0] bal_en_q, bal_en_d;
	logic [CELLS-1:0] bal_out_q, bal_out_d;
	logic [IRQ_W-1:0] irq_sts_q, irq_sts_d;
	logic [IRQ_W-1:0] irq_msk_q, irq_msk_d;
	logic irq_q, irq_d;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	bcdf_apb_slave u_apb (
		.clk_i (clk_i),
		.srst_i (srst_i),
		.psel_i (psel_i),
		.penable_i (penable_i),
		.pwrite_i (pwrite_i),
		.paddr_i (paddr_i),
		.pwdata_i (pwdata_i),
		.pready_o (pready_o),
		.prdata_o (prdata_o),
		.pslverr_o (pslverr_o),
		.rf (rf.slave)
	);

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	// One strobe per register
	assign wr_oc = rf.wr & (rf.idx == IDX_OC);
	assign wr_uc = rf.wr & (rf.idx == IDX_UC);
	assign wr_gen = rf.wr & (rf.idx == IDX_GEN);
	assign wr_bal = rf.wr & (rf.idx == IDX_BAL);
	assign wr_sts = rf.wr & (rf.idx == IDX_IRQ_STS);
	assign wr_msk = rf.wr & (rf.idx == IDX_IRQ_MSK);

	// Clear masks from direct write or general diagnosis zero
	always_comb begin
		oc_clr = '0;
		uc_clr = '0;
		if (wr_oc) begin
			oc_clr = ~rf.wdata[CELLS-1:0];
		end
		if (wr_uc) begin
			uc_clr = ~rf.wdata[CELLS-1:0];
		end
		if (wr_gen & ~rf.wdata[GEN_OC_BIT]) begin
			oc_clr = '1;
		end
		if (wr_gen & ~rf.wdata[GEN_UC_BIT]) begin
			uc_clr = '1;
		end
	end

	// ----------------------------------------------------------------
	// Flag banks
	// ----------------------------------------------------------------
	// Overcurrent flags, bit n for cell n
	bcdf_flag_bank #(
		.N (CELLS)
	) u_oc (
		.clk_i (clk_i),
		.srst_i (srst_i),
		.det_i (oc_detect_i),
		.clr_i (oc_clr),
		.flags_o (oc_flags),
		.rise_o (oc_rise)
	);

	// Undercurrent flags, bit n for cell n
	bcdf_flag_bank #(
		.N (CELLS)
	) u_uc (
		.clk_i (clk_i),
		.srst_i (srst_i),
		.det_i (uc_detect_i),
		.clr_i (uc_clr),
		.flags_o (uc_flags),
		.rise_o (uc_rise)
	);

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	// Reserved and unused bits read zero
	always_comb begin
		rf.rdata = RST_RDATA;
		rf.hit = 1'b1;
		case (rf.idx)
			IDX_OC: begin
				rf.rdata[CELLS-1:0] = oc_flags;
			end
			IDX_UC: begin
				rf.rdata[CELLS-1:0] = uc_flags;
			end
			IDX_GEN: begin
				rf.rdata[GEN_OC_BIT] = |oc_flags;
				rf.rdata[GEN_UC_BIT] = |uc_flags;
			end
			IDX_BAL: begin
				rf.rdata[CELLS-1:0] = bal_en_q;
			end
			IDX_IRQ_STS: begin
				rf.rdata[IRQ_W-1:0] = irq_sts_q;
			end
			IDX_IRQ_MSK: begin
				rf.rdata[IRQ_W-1:0] = irq_msk_q;
			end
			default: begin
				rf.hit = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Control, balancing gate and interrupt
	// ----------------------------------------------------------------
	// Next values of software state and outputs
	always_comb begin
		bal_en_d = bal_en_q;
		irq_msk_d = irq_msk_q;
		irq_sts_d = irq_sts_q;
		if (wr_bal) begin
			bal_en_d = rf.wdata[CELLS-1:0];
		end
		if (wr_msk) begin
			irq_msk_d = rf.wdata[IRQ_W-1:0];
		end
		if (wr_sts) begin
			irq_sts_d = irq_sts_q & ~rf.wdata[IRQ_W-1:0];
		end
		// New fault event wins over a clear
		irq_sts_d[IRQ_OC_BIT] = irq_sts_d[IRQ_OC_BIT] | oc_rise;
		irq_sts_d[IRQ_UC_BIT] = irq_sts_d[IRQ_UC_BIT] | uc_rise;
		irq_d = |(irq_sts_d & irq_msk_d);
		// Faulted cell switched off, others untouched
		bal_out_d = bal_en_d
			& ~(oc_flags | uc_flags | oc_detect_i | uc_detect_i);
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			bal_en_q <= RST_BAL;
			bal_out_q <= RST_BAL;
			irq_sts_q <= RST_IRQ;
			irq_msk_q <= RST_IRQ;
			irq_q <= 1'b0;
		end else begin
			bal_en_q <= bal_en_d;
			bal_out_q <= bal_out_d;
			irq_sts_q <= irq_sts_d;
			irq_msk_q <= irq_msk_d;
			irq_q <= irq_d;
		end
	end

	assign bal_en_o = bal_out_q;
	assign irq_o = irq_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	// Read setup of a flag register
	sequence s_oc_setup;
		psel_i && !penable_i && !pwrite_i && paddr_i == addr_of(IDX_OC);
	endsequence

	sequence s_uc_setup;
		psel_i && !penable_i && !pwrite_i && paddr_i == addr_of(IDX_UC);
	endsequence

	// Write of zero to one general diagnosis bit, no detection pending
	sequence s_gen_zero;
		rf.wr && rf.idx == IDX_GEN && rf.wdata[GEN_OC_BIT] == 1'b0
			&& oc_detect_i == '0;
	endsequence

	sequence s_gen_uc_zero;
		rf.wr && rf.idx == IDX_GEN && rf.wdata[GEN_UC_BIT] == 1'b0
			&& uc_detect_i == '0;
	endsequence

	// Direct write to a flag register, no detection pending
	sequence s_oc_write;
		rf.wr && rf.idx == IDX_OC && oc_detect_i == '0;
	endsequence

	sequence s_uc_write;
		rf.wr && rf.idx == IDX_UC && uc_detect_i == '0;
	endsequence

	a_oc_set_bit: assert property (
		(oc_detect_i != '0)
		|=> ((oc_flags & $past(oc_detect_i)) == $past(oc_detect_i))
	) else $error("overcurrent flag not set by detection");

	a_bal_cell_off: assert property (
		((oc_flags | uc_flags) != '0)
		|-> ((bal_en_o & (oc_flags | uc_flags)) == '0)
	) else $error("balancing still on for a faulted cell");

	a_bal_det_off: assert property (
		((oc_detect_i | uc_detect_i) != '0)
		|=> ((bal_en_o & ($past(oc_detect_i) | $past(uc_detect_i))) == '0)
	) else $error("balancing still on after detection");

	a_bal_cell_keep: assert property (
		(oc_flags == '0 && uc_flags == '0 && oc_detect_i == '0
			&& uc_detect_i == '0 && !rf.wr) [*2]
		|-> bal_en_o == bal_en_q
	) else $error("healthy cell balancing altered");

	a_gen_clear: assert property (
		s_gen_zero |=> oc_flags == '0
	) else $error("general diagnosis zero did not clear flags");

	a_gen_uc_clear: assert property (
		s_gen_uc_zero |=> uc_flags == '0
	) else $error("general diagnosis zero kept undercurrent flags");

	a_uc_set_bit: assert property (
		(uc_detect_i != '0)
		|=> ((uc_flags & $past(uc_detect_i)) == $past(uc_detect_i))
	) else $error("undercurrent flag not set by detection");

	a_res_read_zero: assert property (
		(s_oc_setup or s_uc_setup)
		|=> pready_o && prdata_o[DATA_W-1:CELLS] == '0
	) else $error("reserved bits not zero");

	a_reset_clear: assert property (
		@(posedge clk_i) disable iff (1'b0)
		$past(srst_i) |-> oc_flags == '0 && uc_flags == '0 && !irq_o
	) else $error("flags not zero after reset");

	a_uc_top_bit: assert property (
		uc_detect_i[CELLS-1]
		|=> uc_flags[CELLS-1] [*2] or (uc_flags[CELLS-1] ##1 $past(rf.wr))
	) else $error("cell eleven undercurrent flag lost");

	a_oc_map_read: assert property (
		s_oc_setup |=> prdata_o[CELLS-1:0] == $past(oc_flags) && !pslverr_o
	) else $error("overcurrent register read mismatch");

	a_flag_sticky: assert property (
		!rf.wr |=> ((oc_flags & $past(oc_flags)) == $past(oc_flags))
			&& ((uc_flags & $past(uc_flags)) == $past(uc_flags))
	) else $error("flag dropped without clear");

	a_oc_write_clear: assert property (
		s_oc_write
		|=> oc_flags == ($past(oc_flags) & $past(rf.wdata[CELLS-1:0]))
	) else $error("overcurrent flag write clear wrong");

	a_uc_write_clear: assert property (
		s_uc_write
		|=> uc_flags == ($past(uc_flags) & $past(rf.wdata[CELLS-1:0]))
	) else $error("undercurrent flag write clear wrong");

	a_irq_event: assert property (
		oc_rise |=> irq_sts_q[IRQ_OC_BIT]
	) else $error("new overcurrent flag left no interrupt status");

	a_irq_level: assert property (
		(irq_sts_q & irq_msk_q) != '0 |-> irq_o
	) else $error("interrupt low with unmasked status");

endmodule

// File: rtl/bcdf_pkg.sv
// Constants shared by the balancing current diagnosis flag block.
// Assumes a 32-bit APB register bus and twelve balanced cells.
package bcdf_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int CELLS = 12;
	localparam int REG_W = 16;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;
	localparam int IDX_W = 8;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_OC = 8'h33;
	localparam logic [IDX_W-1:0] IDX_UC = 8'h34;
	localparam logic [IDX_W-1:0] IDX_GEN = 8'h38;
	localparam logic [IDX_W-1:0] IDX_BAL = 8'h39;
	localparam logic [IDX_W-1:0] IDX_IRQ_STS = 8'h3a;
	localparam logic [IDX_W-1:0] IDX_IRQ_MSK = 8'h3b;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int GEN_OC_BIT = 0;
	localparam int GEN_UC_BIT = 1;
	localparam int IRQ_OC_BIT = 0;
	localparam int IRQ_UC_BIT = 1;
	localparam int IRQ_W = 2;
	localparam logic [REG_W-1:0] RST_FLAGS = 16'h0000;
	localparam logic [CELLS-1:0] RST_BAL = 12'h000;
	localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;
	localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

	// Byte address of a register index
	function automatic logic [ADDR_W-1:0] addr_of(
		input logic [IDX_W-1:0] idx
	);
		addr_of = {2'h0, idx, 2'h0};
	endfunction

endpackage

// File: rtl/bcdf_reg_if.sv
// Register access carrier between the APB slave and the register file.
// Assumes one clock; strobes are combinational within the cycle.
`timescale 1ns/1ns
interface bcdf_reg_if;
	import bcdf_pkg::*;

	// Request side
	logic wr;
	logic [IDX_W-1:0] idx;
	logic [DATA_W-1:0] wdata;
	// Answer side
	logic [DATA_W-1:0] rdata;
	logic hit;

	modport slave (output wr, idx, wdata, input rdata, hit);
	modport regs (input wr, idx, wdata, output rdata, hit);
endinterface

// File: rtl/bcdf_apb_slave.sv
// APB slave: decodes word addresses, answers with one wait-free access.
// Assumes APB signals synchronous to clk_i; srst_i synchronous high.
`timescale 1ns/1ns
module bcdf_apb_slave (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [bcdf_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [bcdf_pkg::DATA_W-1:0] pwdata_i,
	output logic pready_o,
	output logic [bcdf_pkg::DATA_W-1:0] prdata_o,
	output logic pslverr_o,
	// Register file
	bcdf_reg_if.slave rf
);
	import bcdf_pkg::*;

	logic setup;
	logic aligned;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [DATA_W-1:0] prdata_q, prdata_d;

	// Decode and write strobe in the access phase
	assign setup = psel_i & ~penable_i;
	assign aligned = (paddr_i[1:0] == 2'h0)
		& (paddr_i[ADDR_W-1:ADDR_W-2] == 2'h0);
	assign rf.idx = paddr_i[IDX_W+1:2];
	assign rf.wdata = pwdata_i;
	assign rf.wr = psel_i & penable_i & pwrite_i & pready_q & aligned & rf.hit;

	// Answer prepared in setup, shown in access
	always_comb begin
		pready_d = setup;
		pslverr_d = setup & ~(aligned & rf.hit);
		prdata_d = RST_RDATA;
		if (setup & ~pwrite_i & aligned & rf.hit) begin
			prdata_d = rf.rdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= RST_RDATA;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign prdata_o = prdata_q;
endmodule

// File: rtl/bcdf_flag_bank.sv
// Sticky per-cell fault flags with set-over-clear priority.
// Assumes detect inputs synchronous to clk_i.
`timescale 1ns/1ns
module bcdf_flag_bank #(
	parameter int N = 12
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Events and clears
	input wire logic [N-1:0] det_i,
	input wire logic [N-1:0] clr_i,
	// State
	output logic [N-1:0] flags_o,
	output logic rise_o
);
	logic [N-1:0] flags_q, flags_d;
	logic rise_q, rise_d;

	// Set wins over clear; flag holds until cleared
	always_comb begin
		flags_d = (flags_q & ~clr_i) | det_i;
		rise_d = |(det_i & ~flags_q);
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			flags_q <= '0;
			rise_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			rise_q <= rise_d;
		end
	end

	assign flags_o = flags_q;
	assign rise_o = rise_q;
endmodule

// File: verif/bcdf_bench.sv
// Self-checking bench for the balancing current diagnosis flag block.
// Assumes bcdf_top answers APB within the watchdog span; assertions in rtl.
`timescale 1ns/1ns
`define CHK(g, e) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("ERROR t=%0t got %h exp %h", $time, g, e); \
	end \
end
module bcdf_bench;
	import bcdf_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk, srst, psel, penable, pwrite, pready, pslverr, irq, er;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [CELLS-1:0] oc_det, uc_det, bal_en;
	int mismatches = 0;
	int tests_run = 0;

	bcdf_top uut (
		.clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
		.oc_detect_i(oc_det), .uc_detect_i(uc_det),
		.bal_en_o(bal_en), .irq_o(irq)
	);

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Bus and stimulus tasks
	// ----------------------------------------------------------------
	// Byte address of a register index
	function automatic logic [ADDR_W-1:0] ad(input logic [IDX_W-1:0] i);
		ad = {2'h0, i, 2'h0};
	endfunction

	// One APB transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r,
		output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d);
		apb(1'b1, ad(i), d, rd, er);
	endtask

	// Read and compare; the caller line names what is checked
	task automatic rc(input logic [IDX_W-1:0] i, input logic [31:0] e);
		apb(1'b0, ad(i), 32'h0000_0000, rd, er);
		`CHK(rd, e)
		`CHK(er, 1'b0)
	endtask

	// One-cycle detector pulse, then time for flag, status and irq
	task automatic det(input logic [11:0] o, input logic [11:0] u);
		@(posedge clk);
		oc_det <= o;
		uc_det <= u;
		@(posedge clk);
		oc_det <= 12'h000;
		uc_det <= 12'h000;
		repeat (3) @(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		`CHK(bal_en, 12'h000)
		`CHK(irq, 1'b0)
		rc(IDX_OC, 32'h0000_0000);
		rc(IDX_UC, 32'h0000_0000);
		rc(IDX_IRQ_STS, 32'h0000_0000);
		rc(IDX_IRQ_MSK, 32'h0000_0000);
		$display("test reset done");
	endtask

	task automatic t_flags();
		wr(IDX_BAL, 32'h0000_0fff);
		wr(IDX_IRQ_MSK, 32'h0000_0003);
		det(12'h400, 12'h800);
		`CHK(bal_en, 12'h3ff)
		`CHK(irq, 1'b1)
		rc(IDX_OC, 32'h0000_0400);
		rc(IDX_UC, 32'h0000_0800);
		wr(IDX_UC, 32'hffff_ffff);
		rc(IDX_UC, 32'h0000_0800);
		wr(IDX_UC, 32'hffff_f7ff);
		rc(IDX_UC, 32'h0000_0000);
		wr(IDX_OC, 32'h0000_0000);
		rc(IDX_OC, 32'h0000_0000);
		det(12'hfff, 12'hfff);
		`CHK(bal_en, 12'h000)
		rc(IDX_OC, 32'h0000_0fff);
		rc(IDX_GEN, 32'h0000_0003);
		wr(IDX_GEN, 32'h0000_0002);
		rc(IDX_OC, 32'h0000_0000);
		rc(IDX_UC, 32'h0000_0fff);
		rc(IDX_GEN, 32'h0000_0002);
		wr(IDX_GEN, 32'h0000_0001);
		rc(IDX_UC, 32'h0000_0000);
		rc(IDX_GEN, 32'h0000_0000);
		$display("test flags done");
	endtask

	// Reset in mid-run with one flag per bank, both status bits and all enables set
	task automatic t_midreset();
		det(12'h001, 12'h800);
		`CHK(bal_en, 12'h7fe)
		`CHK(irq, 1'b1)
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		`CHK(bal_en, 12'h000)
		`CHK(irq, 1'b0)
		rc(IDX_OC, 32'h0000_0000);
		rc(IDX_UC, 32'h0000_0000);
		rc(IDX_BAL, 32'h0000_0000);
		rc(IDX_IRQ_STS, 32'h0000_0000);
		rc(IDX_IRQ_MSK, 32'h0000_0000);
		$display("test midreset done");
	endtask

	task automatic t_irq();
		rc(IDX_IRQ_STS, 32'h0000_0003);
		wr(IDX_IRQ_MSK, 32'h0000_0000);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		wr(IDX_IRQ_MSK, 32'h0000_0003);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		wr(IDX_IRQ_STS, 32'h0000_0003);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		rc(IDX_IRQ_STS, 32'h0000_0000);
		$display("test irq done");
	endtask

	task automatic t_unmapped();
		apb(1'b0, ad(8'h35), 32'h0000_0000, rd, er);
		`CHK(er, 1'b1)
		`CHK(rd, 32'h0000_0000)
		apb(1'b0, 12'h0cd, 32'h0000_0000, rd, er);
		`CHK(er, 1'b1)
		$display("test unmapped done");
	endtask

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog, well beyond the about 135 cycles the tests need
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		close_out();
	end

	// Main sequence
	initial begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		oc_det = '0;
		uc_det = '0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_flags();
		t_irq();
		t_midreset();
		t_unmapped();
		close_out();
	end
endmodule
